/* File: bench/brk_checker_assertions.sv */
// Port-level concurrent checks for the clock breakpoint unit
`default_nettype none

module brk_checker
  import brk_pkg::*;
#(
  parameter int SNAP_PERIOD = 50
) (
  // Unit clock, reset and register port
  input wire logic                   i_clk,
  input wire logic                   i_arst_n,
  input wire logic [ADDR_W-1:0]      i_addr,
  input wire logic [DATA_W-1:0]      i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [DATA_W-1:0]      o_rdata,
  // Probe and domains
  input wire logic                   i_probe_trig,
  input wire logic [NUM_DOMAINS-1:0] i_dom_clk,
  input wire logic [NUM_DOMAINS-1:0] o_gated_clock_outputs,
  input wire logic [NUM_DOMAINS-1:0] o_halted
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Shadow of scope, armed and delay state
  // ----------------------------------------------------------------
  logic             all_q;
  logic             all_d;
  logic [DOM_W-1:0] sel_q;
  logic [DOM_W-1:0] sel_d;
  logic             armed_q;
  logic             armed_d;
  logic             dz_q;
  logic             dz_d;
  logic [3:0]       hp_q;
  wire logic        wcmd = i_wr && (i_addr == CMD_ADDR);

  // Armed ends on any new halt, which covers trigger and force halt alike
  always_comb begin
    all_d   = all_q;
    sel_d   = sel_q;
    dz_d    = dz_q;
    armed_d = armed_q;
    if (i_wr && i_addr == CTRL_ADDR) begin
      all_d = i_wdata[CTRL_ALL_BIT];
      sel_d = i_wdata[CTRL_SEL_LSB +: DOM_W];
    end
    if (i_wr && i_addr == DELAY_ADDR) dz_d = (i_wdata[7:0] == 8'h00);
    if ((wcmd && i_wdata[CMD_HALT_BIT]) || |(o_halted & ~hp_q)) armed_d = 1'b0;
    else if (wcmd && i_wdata[CMD_ARM_BIT] && !i_probe_trig) armed_d = 1'b1;
  end

  // Shadow registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      all_q   <= 1'b0;
      sel_q   <= '0;
      dz_q    <= 1'b1;
      armed_q <= 1'b0;
      hp_q    <= 4'h0;
    end else begin
      all_q   <= all_d;
      sel_q   <= sel_d;
      dz_q    <= dz_d;
      armed_q <= armed_d;
      hp_q    <= o_halted;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_stop_walk;
    o_halted[0] && !o_halted[3] ##1 o_halted[1] ##1 o_halted[2] ##1 o_halted[3];
  endsequence
  sequence s_run_walk;
    !o_halted[0] && o_halted[3] ##1 !o_halted[1] ##1 !o_halted[2] ##1 !o_halted[3];
  endsequence

  property p_rd_idle;
    !i_rd |=> o_rdata == '0;
  endproperty
  property p_sts;
    i_rd && i_addr == STATUS_ADDR |=> o_rdata[3:0] == $past(o_halted);
  endproperty
  property p_halt_one;
    wcmd && i_wdata[CMD_HALT_BIT] && !all_q |=> o_halted == ($past(o_halted) | (4'h1 << sel_q));
  endproperty
  property p_play_one;
    wcmd && i_wdata[CMD_PLAY_BIT] && !all_q && !armed_q
      |=> o_halted == ($past(o_halted) & ~(4'h1 << sel_q));
  endproperty
  property p_halt_all;
    wcmd && i_wdata[CMD_HALT_BIT] && all_q && o_halted == 4'h0 |=> s_stop_walk;
  endproperty
  property p_play_all;
    wcmd && i_wdata[CMD_PLAY_BIT] && all_q && !armed_q && o_halted == 4'hf |=> ##1 s_run_walk;
  endproperty
  property p_step_keep;
    wcmd && i_wdata[CMD_STEP_BIT] && !armed_q |=> $stable(o_halted);
  endproperty
  property p_arm_high;
    wcmd && i_wdata[CMD_ARM_BIT] && i_probe_trig && !armed_q && !all_q |=> o_halted[sel_q];
  endproperty
  property p_trig_rise;
    armed_q && dz_q && !all_q && i_probe_trig && !$past(i_probe_trig)
      |=> !o_halted[sel_q] ##1 o_halted[sel_q];
  endproperty

  a_rd_idle:   assert property (p_rd_idle) else $error("read data not idle");
  a_sts:       assert property (p_sts) else $error("status halted bits wrong");
  a_halt_one:  assert property (p_halt_one) else $error("single halt wrong");
  a_play_one:  assert property (p_play_one) else $error("single play wrong");
  a_halt_all:  assert property (p_halt_all) else $error("halt order wrong");
  a_play_all:  assert property (p_play_all) else $error("play order wrong");
  a_step_keep: assert property (p_step_keep) else $error("step changed halt");
  a_arm_high:  assert property (p_arm_high) else $error("arm on high no halt");
  a_trig_rise: assert property (p_trig_rise) else $error("trigger halt timing");
endmodule

bind clock_breakpoint_unit brk_checker #(.SNAP_PERIOD(SNAP_PERIOD)) brk_checker_inst (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_probe_trig(i_probe_trig), .i_dom_clk(i_dom_clk),
  .o_gated_clock_outputs(o_gated_clock_outputs), .o_halted(o_halted));

`default_nettype wire

/* File: bench/tb_clock_breakpoint_unit.sv */
// Self-checking bench for the clock breakpoint unit
`default_nettype none

module tb_clock_breakpoint_unit
  import brk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SNAP_P = 50;

  logic              i_clk = 1'b0;
  logic              i_arst_n = 1'b0;
  logic [7:0]        i_addr = 8'h00;
  logic [31:0]       i_wdata = 32'h0;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic              i_probe_trig = 1'b0;
  logic [31:0]       o_rdata;
  logic [3:0]        dom_clk;
  logic [3:0]        gated;
  logic [3:0]        o_halted;
  logic [3:0][15:0]  edges;
  logic [3:0]        short_hi;
  logic [31:0]       rv;
  logic [15:0]       e0;
  logic [15:0]       e1;
  int                fails = 0;
  int                tests_run = 0;
  int                n;

  // Ordinary cases: {ctrl, cmd, expected halted}
  localparam logic [11:0] ROWS [12] = '{12'h021, 12'h223, 12'h427, 12'h62f,
    12'h24d, 12'h28d, 12'h08d, 12'h140, 12'h12f, 12'h18f, 12'h140, 12'h440};
  localparam logic [7:0] ZADDR [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

  always #25 i_clk = ~i_clk;

  clock_breakpoint_unit #(.SNAP_PERIOD(SNAP_P)) clock_breakpoint_unit_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_probe_trig(i_probe_trig), .i_dom_clk(dom_clk),
    .o_gated_clock_outputs(gated), .o_halted(o_halted));

  user_domains user_domains_inst (
    .o_dom_clk(dom_clk), .i_gated(gated), .o_edges(edges), .o_short(short_hi));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge i_clk);
      i_probe_trig <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_probe_trig <= 1'b0;
      @(posedge i_clk);
    end
  endtask

  task automatic results;
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog sized well past the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Reset values, write-only and unmapped places read zero
    foreach (ZADDR[i]) begin
      rd(ZADDR[i], rv);
      chk("reset_read", 32'h0, rv);
    end
    // Halt, play and step in both scopes
    foreach (ROWS[i]) begin
      wr(CTRL_ADDR, {28'h0, ROWS[i][11:8]});
      wr(CMD_ADDR, {28'h0, ROWS[i][7:4]});
      repeat (6) @(posedge i_clk);
      rd(STATUS_ADDR, rv);
      chk("halted", {28'h0, ROWS[i][3:0]}, {28'h0, rv[3:0]});
    end
    // Stopped clock stays still, neighbours run, one step gives one edge
    wr(CTRL_ADDR, 32'h0);
    wr(CMD_ADDR, 32'h2);
    #1 e0 = edges[0];
    repeat (20) @(posedge i_clk);
    chk("halt_latency", 32'h1, {31'h0, edges[0] - e0 < 16'h2});
    e0 = edges[0];
    e1 = edges[1];
    repeat (20) @(posedge i_clk);
    chk("stopped_edges", {16'h0, e0}, {16'h0, edges[0]});
    chk("others_run", 32'h1, {31'h0, edges[1] != e1});
    wr(CMD_ADDR, 32'h8);
    repeat (20) @(posedge i_clk);
    chk("step_edges", {16'h0, e0 + 16'h1}, {16'h0, edges[0]});
    // Play is refused while armed; force halt disarms
    wr(CMD_ADDR, 32'h1);
    wr(CMD_ADDR, 32'h4);
    rd(STATUS_ADDR, rv);
    chk("armed_refuse", 32'h1, {31'h0, rv[0]});
    wr(CMD_ADDR, 32'h2);
    wr(CMD_ADDR, 32'h4);
    rd(STATUS_ADDR, rv);
    chk("after_disarm", 32'h0, {28'h0, rv[3:0]});
    // Arming on a high trigger halts at once
    i_probe_trig <= 1'b1;
    wr(CTRL_ADDR, 32'h6);
    wr(CMD_ADDR, 32'h1);
    rd(STATUS_ADDR, rv);
    chk("arm_high", 32'h8, {28'h0, rv[3:0]});
    i_probe_trig <= 1'b0;
    wr(CMD_ADDR, 32'h4);
    // Trigger delay at both ends of its range
    for (int i = 0; i < 2; i++) begin
      wr(DELAY_ADDR, i == 0 ? 32'h0 : 32'hff);
      rd(DELAY_ADDR, rv);
      chk("delay_reg", i == 0 ? 32'h0 : 32'hff, rv);
      wr(CTRL_ADDR, 32'h4);
      wr(CMD_ADDR, 32'h1);
      i_probe_trig <= 1'b1;
      n = 0;
      while (o_halted[2] !== 1'b1 && n < 400) begin
        @(posedge i_clk);
        #1 n++;
      end
      chk("trig_delay", i == 0 ? 32'd2 : 32'd257, n);
      i_probe_trig <= 1'b0;
      wr(CMD_ADDR, 32'h4);
    end
    // Event counter: periodic snapshot, final total, empty run
    wr(CMD_ADDR, 32'h10);
    pulses(3);
    repeat (60) @(posedge i_clk);
    rd(SNAP_ADDR, rv);
    chk("snapshot", 32'd3, rv);
    pulses(2);
    wr(CMD_ADDR, 32'h20);
    rd(SNAP_ADDR, rv);
    chk("final_count", 32'd5, rv);
    wr(CMD_ADDR, 32'h10);
    repeat (5) @(posedge i_clk);
    wr(CMD_ADDR, 32'h20);
    rd(SNAP_ADDR, rv);
    chk("empty_count", 32'd0, rv);
    chk("no_glitch", 32'h0, {28'h0, short_hi});
    results();
  end
endmodule

`default_nettype wire

/* File: bench/user_domains.sv */
// User clock domains: free clocks out, gated clock edges counted back
`default_nettype none

module user_domains (
  // Free-running domain clocks
  output logic      [3:0]       o_dom_clk,
  // Gated clocks back from the unit
  input  wire logic [3:0]       i_gated,
  output logic      [3:0][15:0] o_edges,
  output logic      [3:0]       o_short
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF [4] = '{25, 35, 45, 55};

  // All domains at or below unit rate; a short high pulse marks a glitch
  for (genvar g = 0; g < 4; g++) begin : g_dom
    realtime t_up;
    initial begin
      o_dom_clk[g] = 1'b0;
      o_edges[g]   = 16'h0000;
      o_short[g]   = 1'b0;
      forever #(HALF[g]) o_dom_clk[g] = ~o_dom_clk[g];
    end
    always @(posedge i_gated[g]) begin
      o_edges[g] <= o_edges[g] + 16'h0001;
      t_up = $realtime;
    end
    always @(negedge i_gated[g]) begin
      if ($realtime - t_up < HALF[g] - 1) o_short[g] <= 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: rtl/brk_pkg.sv */
// Constants and carrier types for the clock domain breakpoint unit
// Contract
// [R1] Arming while the trigger is already high halts the target at once.
// [R2] A detected armed trigger halts the selected domain or all domains per scope.
// [R3] Only a rising trigger transition fires; falling edges never do.
// [R4] The halt delay after a trigger is at most 255 cycles.
// [R5] The halt delay is counted in cycles of the unit's own clock.
// [R6] A domain at or below unit rate stops within its own cycle of halt.
// [R7] Force halt stops the selected or all domains without any trigger.
// [R8] Play on a halted domain releases its clock gate to resume running.
// [R9] Step on a halted domain passes exactly one clock, then holds it.
// [R10] In all scope, force halt stops domains one by one in fixed order.
// [R11] In all scope, play resumes domains one by one in the same order.
// [R12] In all scope, step advances domains one by one in the same order.
// [R13] Halting one selected domain leaves all other domain clocks running.
// [R14] A per-domain halted status is readable by the host.
// [R15] An active event counter increments on each rising probe transition.
// [R16] While counting, a snapshot of the total is refreshed every second.
// [R17] Host stops the event counter before reading the final total.
// [R18] Old unit reported one on stop with no edges; this one reports zero.
// [R19] Host loads a delay of 0 to 255 before arming, from the rising edge.
// [R20] A forced halt ignores the programmed trigger delay.
// [R21] While armed, other breakpoint commands are ignored until trigger or force halt.
// [R22] Each domain uses a glitch-free clock gate so no partial pulse escapes.
`default_nettype none

package brk_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int          NUM_DOMAINS  = 4;
  localparam int          DOM_W        = 2;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          DELAY_W      = 8;
  localparam logic [7:0]  DELAY_MAX    = 8'hff;
  localparam longint      CLK_HZ       = 20_000_000;
  localparam int          SNAP_SEC     = 1;
  localparam int          SNAP_CYCLES  = int'(CLK_HZ * SNAP_SEC);

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  DELAY_ADDR   = 8'h04;
  localparam logic [7:0]  CMD_ADDR     = 8'h08;
  localparam logic [7:0]  STATUS_ADDR  = 8'h0c;
  localparam logic [7:0]  SNAP_ADDR    = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_ALL_BIT = 0;
  localparam int          CTRL_SEL_LSB = 1;
  localparam int          CMD_ARM_BIT  = 0;
  localparam int          CMD_HALT_BIT = 1;
  localparam int          CMD_PLAY_BIT = 2;
  localparam int          CMD_STEP_BIT = 3;
  localparam int          CMD_CSTA_BIT = 4;
  localparam int          CMD_CSTO_BIT = 5;
  localparam int          STS_ARM_BIT  = 4;
  localparam int          STS_DLY_BIT  = 5;
  localparam int          STS_SEQ_BIT  = 6;
  localparam int          STS_CNT_BIT  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  DELAY_RST    = 8'h00;
  localparam logic [3:0]  HALT_RST     = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TRG_IDLE, TRG_ARMED, TRG_DELAY} trg_state_type;
  typedef enum logic [1:0] {OP_NONE, OP_HALT, OP_PLAY, OP_STEP} seq_op_type;

  // Software control word
  typedef struct packed {
    logic             all_scope;
    logic [DOM_W-1:0] sel;
  } ctrl_type;

  // One-cycle commands decoded from a command write
  typedef struct packed {
    logic arm;
    logic halt;
    logic play;
    logic step;
    logic cnt_start;
    logic cnt_stop;
  } cmd_type;

  // Decoded command from a write word
  function automatic cmd_type cmd_decode(input logic [DATA_W-1:0] w);
    cmd_type c;
    c.arm       = w[CMD_ARM_BIT];
    c.halt      = w[CMD_HALT_BIT];
    c.play      = w[CMD_PLAY_BIT];
    c.step      = w[CMD_STEP_BIT];
    c.cnt_start = w[CMD_CSTA_BIT];
    c.cnt_stop  = w[CMD_CSTO_BIT];
    return c;
  endfunction

endpackage

`default_nettype wire

/* File: rtl/clock_breakpoint_unit.sv */
// Clock domain breakpoint unit: trigger, halt, play, step and event counter
`default_nettype none

module clock_breakpoint_unit
  import brk_pkg::*;
#(
  parameter int SNAP_PERIOD = SNAP_CYCLES
) (
  // Unit clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]      i_addr,
  input  wire logic [DATA_W-1:0]      i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [DATA_W-1:0]      o_rdata,
  // Probe trigger channel
  input  wire logic                   i_probe_trig,
  // User domain clocks
  input  wire logic [NUM_DOMAINS-1:0] i_dom_clk,
  output wire logic [NUM_DOMAINS-1:0] o_gated_clock_outputs,
  // Per-domain halted status
  output logic      [NUM_DOMAINS-1:0] o_halted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_type                ctrl_q,     ctrl_d;
  logic [DELAY_W-1:0]      delay_q,    delay_d;
  logic [NUM_DOMAINS-1:0]  halt_q,     halt_d;
  logic [NUM_DOMAINS-1:0]  step_tgl_q, step_tgl_d;
  trg_state_type           trg_q,      trg_d;
  logic [DELAY_W-1:0]      dcnt_q,     dcnt_d;
  seq_op_type              seq_op_q,   seq_op_d;
  logic [DOM_W-1:0]        seq_idx_q,  seq_idx_d;
  logic                    trig_prev_q;
  logic                    cnt_run_q,  cnt_run_d;
  logic [DATA_W-1:0]       evt_q,      evt_d;
  logic [DATA_W-1:0]       snap_q,     snap_d;
  logic [31:0]             sec_q,      sec_d;
  logic [DATA_W-1:0]       rdata_d;

  cmd_type                 cmd;
  logic                    trig_rise;
  logic                    do_halt;
  logic                    do_force;

  // ----------------------------------------------------------------
  // Command decode and edge detect
  // ----------------------------------------------------------------
  // The probe is taken as synchronous, so one delay flop is enough
  always_comb begin
    cmd       = (i_wr && i_addr == CMD_ADDR) ? cmd_decode(i_wdata) : '0;
    trig_rise = i_probe_trig & ~trig_prev_q;  // Rising only, falling ignored [R3]
    do_force  = cmd.halt;                     // Always honoured, even while armed [R21]
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    delay_d = delay_q;
    if (i_wr && i_addr == CTRL_ADDR) begin
      ctrl_d.all_scope = i_wdata[CTRL_ALL_BIT];
      ctrl_d.sel       = i_wdata[CTRL_SEL_LSB +: DOM_W];
    end
    // Eight-bit field cannot hold more than the largest delay [R4] [R19]
    if (i_wr && i_addr == DELAY_ADDR) begin
      delay_d = i_wdata[DELAY_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Trigger arming and delay counter
  // ----------------------------------------------------------------
  // Delay counts unit clock cycles, not user domain cycles [R5]
  always_comb begin
    trg_d   = trg_q;
    dcnt_d  = dcnt_q;
    do_halt = 1'b0;
    case (trg_q)
      TRG_IDLE: begin
        if (cmd.arm && !do_force) begin
          if (i_probe_trig) begin
            do_halt = 1'b1;                   // Already high at arm time [R1]
          end else begin
            trg_d = TRG_ARMED;
          end
        end
      end
      TRG_ARMED: begin
        if (do_force) begin
          trg_d = TRG_IDLE;                   // Force halt disarms [R21]
        end else if (trig_rise) begin
          dcnt_d = '0;
          trg_d  = TRG_DELAY;
        end
      end
      TRG_DELAY: begin
        if (do_force) begin
          trg_d = TRG_IDLE;
        end else if (dcnt_q == delay_q) begin
          do_halt = 1'b1;                     // Armed trigger halts per scope [R2]
          trg_d   = TRG_IDLE;
        end else begin
          dcnt_d = dcnt_q + 1'b1;             // At most DELAY_MAX steps [R4]
        end
      end
      default: begin
        trg_d = TRG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Halt, play and step control with all-domain sequencer
  // ----------------------------------------------------------------
  // All-scope operations walk the domains 0..3, one per cycle, so that the
  // gated clocks never switch together and the order is fixed
  always_comb begin
    halt_d     = halt_q;
    step_tgl_d = step_tgl_q;
    seq_op_d   = seq_op_q;
    seq_idx_d  = seq_idx_q;

    // Advance a running sequence first
    case (seq_op_q)
      OP_HALT: begin
        halt_d[seq_idx_q] = 1'b1;             // [R10]
      end
      OP_PLAY: begin
        halt_d[seq_idx_q] = 1'b0;             // [R11]
      end
      OP_STEP: begin
        if (halt_q[seq_idx_q]) begin
          step_tgl_d[seq_idx_q] = ~step_tgl_q[seq_idx_q];  // [R12]
        end
      end
      default: begin
      end
    endcase
    if (seq_op_q != OP_NONE) begin
      if (seq_idx_q == DOM_W'(NUM_DOMAINS - 1)) begin
        seq_op_d = OP_NONE;
      end else begin
        seq_idx_d = seq_idx_q + 1'b1;
      end
    end

    // New requests; a halt request overrides any sequence in flight
    if (do_force || do_halt) begin
      // No delay applies to a forced halt [R7] [R20]
      if (ctrl_q.all_scope) begin
        halt_d[0] = 1'b1;                     // First domain stops this cycle [R10]
        seq_op_d  = OP_HALT;
        seq_idx_d = DOM_W'(1);
      end else begin
        halt_d[ctrl_q.sel] = 1'b1;            // Other domains untouched [R13]
        seq_op_d           = OP_NONE;
      end
    end else if (trg_q == TRG_IDLE && seq_op_q == OP_NONE) begin
      // Play and step only while disarmed and idle [R21]
      if (cmd.play) begin
        if (ctrl_q.all_scope) begin
          seq_op_d  = OP_PLAY;
          seq_idx_d = '0;
        end else begin
          halt_d[ctrl_q.sel] = 1'b0;          // Release the gate [R8]
        end
      end else if (cmd.step) begin
        if (ctrl_q.all_scope) begin
          seq_op_d  = OP_STEP;
          seq_idx_d = '0;
        end else if (halt_q[ctrl_q.sel]) begin
          step_tgl_d[ctrl_q.sel] = ~step_tgl_q[ctrl_q.sel];  // One cycle [R9]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event counter with one-second snapshot
  // ----------------------------------------------------------------
  // Unlike the older unit, a stop with no edges reports zero [R18]
  always_comb begin
    cnt_run_d = cnt_run_q;
    evt_d     = evt_q;
    snap_d    = snap_q;
    sec_d     = sec_q;
    if (cmd.cnt_start) begin
      cnt_run_d = 1'b1;
      evt_d     = '0;
      snap_d    = '0;
      sec_d     = '0;
    end else if (cnt_run_q) begin
      if (trig_rise) begin
        evt_d = evt_q + 1'b1;                 // [R15]
      end
      if (cmd.cnt_stop) begin
        cnt_run_d = 1'b0;
        snap_d    = trig_rise ? evt_q + 1'b1 : evt_q;  // Final total after stop [R17]
      end else if (sec_q == 32'(SNAP_PERIOD - 1)) begin
        sec_d  = '0;
        snap_d = evt_q;                       // Periodic refresh [R16]
      end else begin
        sec_d = sec_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        CTRL_ADDR: begin
          rdata_d[CTRL_ALL_BIT]           = ctrl_q.all_scope;
          rdata_d[CTRL_SEL_LSB +: DOM_W]  = ctrl_q.sel;
        end
        DELAY_ADDR: begin
          rdata_d[DELAY_W-1:0] = delay_q;
        end
        STATUS_ADDR: begin
          rdata_d[NUM_DOMAINS-1:0] = halt_q;  // Per-domain halted view [R14]
          rdata_d[STS_ARM_BIT]     = (trg_q == TRG_ARMED);
          rdata_d[STS_DLY_BIT]     = (trg_q == TRG_DELAY);
          rdata_d[STS_SEQ_BIT]     = (seq_op_q != OP_NONE);
          rdata_d[STS_CNT_BIT]     = cnt_run_q;
        end
        SNAP_ADDR: begin
          rdata_d = snap_q;
        end
        default: begin
          rdata_d = '0;                       // Unmapped and command reads give zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q      <= '0;
      delay_q     <= DELAY_RST;
      halt_q      <= HALT_RST;
      step_tgl_q  <= '0;
      trg_q       <= TRG_IDLE;
      dcnt_q      <= '0;
      seq_op_q    <= OP_NONE;
      seq_idx_q   <= '0;
      trig_prev_q <= 1'b0;
      cnt_run_q   <= 1'b0;
      evt_q       <= '0;
      snap_q      <= '0;
      sec_q       <= '0;
      o_rdata     <= '0;
      o_halted    <= HALT_RST;
    end else begin
      ctrl_q      <= ctrl_d;
      delay_q     <= delay_d;
      halt_q      <= halt_d;
      step_tgl_q  <= step_tgl_d;
      trg_q       <= trg_d;
      dcnt_q      <= dcnt_d;
      seq_op_q    <= seq_op_d;
      seq_idx_q   <= seq_idx_d;
      trig_prev_q <= i_probe_trig;
      cnt_run_q   <= cnt_run_d;
      evt_q       <= evt_d;
      snap_q      <= snap_d;
      sec_q       <= sec_d;
      o_rdata     <= rdata_d;
      o_halted    <= halt_d;                  // Mirrors halt_q, from a flop [R14]
    end
  end

  // ----------------------------------------------------------------
  // One glitch-free gate per domain
  // ----------------------------------------------------------------
  // Halt reaches each gate unsynchronised, so a domain at or below unit rate
  // stops at its next falling edge; faster domains are not bounded
  for (genvar g = 0; g < NUM_DOMAINS; g++) begin : g_gate
    domain_clock_gate u_gate (
      .i_dom_clk   (i_dom_clk[g]),
      .i_arst_n    (i_arst_n),
      .i_run       (~halt_q[g]),             // [R6] [R13]
      .i_step_tgl  (step_tgl_q[g]),
      .o_gated_clk (o_gated_clock_outputs[g])
    );
  end

endmodule

`default_nettype wire

/* File: rtl/domain_clock_gate.sv */
// Glitch-free clock gate with single-step for one user clock domain
`default_nettype none

module domain_clock_gate (
  // User domain clock and reset
  input  wire logic i_dom_clk,
  input  wire logic i_arst_n,
  // Control from the breakpoint unit clock
  input  wire logic i_run,
  input  wire logic i_step_tgl,
  // Gated clock to the user logic
  output wire logic o_gated_clk
);

  logic stp_s1_q,  stp_s1_d;
  logic stp_s2_q,  stp_s2_d;
  logic stp_s3_q,  stp_s3_d;
  logic en_pos_q,  en_pos_d;
  logic en_neg_q,  en_neg_d;

  // ----------------------------------------------------------------
  // Synchronise the step toggle into the user domain
  // ----------------------------------------------------------------
  // Only the second and third stages are compared; the first stage feeds the second alone.
  // Run is taken straight from the unit clock so a halt lands within one
  // user cycle [R6]; the price is a metastability window on en_neg_q alone
  always_comb begin
    stp_s1_d = i_step_tgl;
    stp_s2_d = stp_s1_q;
    stp_s3_d = stp_s2_q;
    en_pos_d = stp_s2_q ^ stp_s3_q;  // One step edge opens one cycle [R9]
    en_neg_d = i_run | en_pos_q;
  end

  always_ff @(posedge i_dom_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stp_s1_q <= 1'b0;
      stp_s2_q <= 1'b0;
      stp_s3_q <= 1'b0;
      en_pos_q <= 1'b0;
    end else begin
      stp_s1_q <= stp_s1_d;
      stp_s2_q <= stp_s2_d;
      stp_s3_q <= stp_s3_d;
      en_pos_q <= en_pos_d;
    end
  end

  // ----------------------------------------------------------------
  // Enable changes only while the clock is low
  // ----------------------------------------------------------------
  // Sampling on the falling edge keeps the AND from cutting a high phase [R22]
  always_ff @(negedge i_dom_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_neg_q <= 1'b1;
    end else begin
      en_neg_q <= en_neg_d;
    end
  end

  assign o_gated_clk = i_dom_clk & en_neg_q;  // [R22]

endmodule

`default_nettype wire
